// ---- hw/dcw3_top.sv ----
// configuration word three: load, pin ownership, reconfig locks, user id
//
// Contract
// - vbus-on owner bit gives pin to usb
// - usb-id owner bit gives pin to usb
// - single pin remap reconfig when bit set
// - single module disable reconfig when bit set
// - user id readable by programmer and jtag
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module dcw3_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // nonvolatile storage read port
  output logic NV_RD_REQ,
  input wire logic NV_RD_VALID,
  input wire logic [31:0] NV_RD_DATA,
  // vbus_on_pin pad
  input wire logic VBUS_ON_PIN_I,
  output logic VBUS_ON_PIN_O,
  output logic VBUS_ON_PIN_OE,
  // usb_id_pin pad
  input wire logic USB_ID_PIN_I,
  output logic USB_ID_PIN_O,
  output logic USB_ID_PIN_OE,
  // usb module side of both pins
  input wire logic USB_VBUS_ON_O,
  input wire logic USB_VBUS_ON_OE,
  output logic USB_VBUS_ON_I,
  input wire logic USB_ID_O,
  input wire logic USB_ID_OE,
  output logic USB_ID_I,
  // port logic side of both pins
  input wire logic PORT_VBUS_ON_O,
  input wire logic PORT_VBUS_ON_OE,
  output logic PORT_VBUS_ON_I,
  input wire logic PORT_USB_ID_O,
  input wire logic PORT_USB_ID_OE,
  output logic PORT_USB_ID_I,
  // settings driven into the device
  output logic [31:0] PIN_REMAP,
  output logic [31:0] MODULE_DISABLE,
  // user_identifier toward programming port and jtag
  output logic [15:0] PROG_USER_ID,
  output logic [15:0] JTAG_USER_ID
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // a write is refused before load, or once used in single mode
  function automatic logic wr_refused(input logic loaded,
                                      input logic single,
                                      input logic used);
    wr_refused = ~loaded | (single & used);
  endfunction

  // address match on a full aligned byte offset
  function automatic logic addr_hit(input logic [11:0] addr,
                                    input logic [11:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  dcw3_pkg::dcw3_load_t ld_q; // load sequencer state
  dcw3_pkg::dcw3_load_t ld_d; // its next value
  logic [31:0] cfg_q; // loaded configuration word
  logic [31:0] cfg_d; // its next value
  logic [31:0] remap_q; // peripheral pin mapping
  logic [31:0] remap_d;
  logic [31:0] mdis_q; // peripheral module disable
  logic [31:0] mdis_d;
  logic remap_used_q; // mapping accepted a write
  logic remap_used_d;
  logic mdis_used_q; // module disable accepted a write
  logic mdis_used_d;

  ////////////////////////////////////////////////////////////////////////////
  // load sequencer: fetch the word once after reset release

  // word arrives in the request state
  wire logic ld_take = (ld_q == dcw3_pkg::LD_REQ) & NV_RD_VALID;
  // word is valid and frozen
  wire logic loaded = (ld_q == dcw3_pkg::LD_DONE);

  // next state of the sequencer
  always_comb begin
    ld_d = ld_q;
    unique case (ld_q)
      // first cycle after release, start the fetch
      dcw3_pkg::LD_START: begin
        ld_d = dcw3_pkg::LD_REQ;
      end
      // hold the request until storage answers
      dcw3_pkg::LD_REQ: begin
        if (NV_RD_VALID) begin
          ld_d = dcw3_pkg::LD_DONE;
        end
      end
      // stays here until the next reset
      dcw3_pkg::LD_DONE: begin
        ld_d = dcw3_pkg::LD_DONE;
      end
    endcase
  end

  // request is a level while waiting
  // a valid seen outside the request state is ignored
  assign NV_RD_REQ = (ld_q == dcw3_pkg::LD_REQ);

  // word captured only once, so settings cannot move until reset
  assign cfg_d = ld_take ? NV_RD_DATA : cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields

  // ownership selects, port owns both pins until the load
  wire logic vbus_usb_owns = cfg_q[dcw3_pkg::BIT_VBUS_ON_OWNER];
  wire logic id_usb_owns = cfg_q[dcw3_pkg::BIT_USB_ID_OWNER];
  // single reconfiguration modes
  wire logic remap_single = cfg_q[dcw3_pkg::BIT_REMAP_SINGLE];
  wire logic mdis_single = cfg_q[dcw3_pkg::BIT_MDIS_SINGLE];
  // reserved field as programmed
  wire logic [11:0] rsvd = cfg_q[dcw3_pkg::RSVD_MSB:dcw3_pkg::RSVD_LSB];
  // reports whether the programmer kept reserved bits at one
  wire logic rsvd_ok = (rsvd == dcw3_pkg::RSVD_ALL_ONES);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // access phase, every access completes in its first access cycle
  wire logic apb_acc = PSEL & PENABLE;
  wire logic apb_wr = apb_acc & PWRITE;
  // register selects
  // full offset compare, so an aliased or unaligned address is unmapped
  wire logic sel_cfg = addr_hit(PADDR, dcw3_pkg::OFS_CFG_WORD);
  wire logic sel_stat = addr_hit(PADDR, dcw3_pkg::OFS_STATUS);
  wire logic sel_remap = addr_hit(PADDR, dcw3_pkg::OFS_PIN_REMAP);
  wire logic sel_mdis = addr_hit(PADDR, dcw3_pkg::OFS_MOD_DISABLE);
  wire logic sel_any = sel_cfg | sel_stat | sel_remap | sel_mdis;

  // lock state of the two reconfigurable settings
  wire logic remap_lock = wr_refused(loaded, remap_single, remap_used_q);
  wire logic mdis_lock = wr_refused(loaded, mdis_single, mdis_used_q);

  // writes that are taken
  wire logic remap_wr = apb_wr & sel_remap & ~remap_lock;
  wire logic mdis_wr = apb_wr & sel_mdis & ~mdis_lock;

  // error: unmapped, read-only target, or locked setting
  // a refused write still completes, only the error flag tells the master
  wire logic err_ro = PWRITE & (sel_cfg | sel_stat);
  wire logic err_lock = PWRITE & ((sel_remap & remap_lock) | (sel_mdis & mdis_lock));
  wire logic err_any = ~sel_any | err_ro | err_lock;

  ////////////////////////////////////////////////////////////////////////////
  // reconfigurable settings next values

  // used flags never clear, only a reset reopens a single-mode setting
  // mapping, first write marks it used
  assign remap_d = remap_wr ? PWDATA : remap_q;
  assign remap_used_d = remap_used_q | remap_wr;
  // module disable, same scheme
  assign mdis_d = mdis_wr ? PWDATA : mdis_q;
  assign mdis_used_d = mdis_used_q | mdis_wr;

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  // sequencer and loaded word
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ld_q <= dcw3_pkg::LD_START;
      cfg_q <= dcw3_pkg::CFG_RESET;
    end else begin
      ld_q <= ld_d;
      cfg_q <= cfg_d;
    end
  end

  // reconfigurable settings and their use flags
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      remap_q <= dcw3_pkg::PIN_REMAP_RESET;
      mdis_q <= dcw3_pkg::MOD_DISABLE_RESET;
      remap_used_q <= 1'b0;
      mdis_used_q <= 1'b0;
    end else begin
      remap_q <= remap_d;
      mdis_q <= mdis_d;
      remap_used_q <= remap_used_d;
      mdis_used_q <= mdis_used_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word

  logic [31:0] status;

  // gather state bits, others read zero
  // lock bits already cover the not-loaded case
  always_comb begin
    status = dcw3_pkg::RDATA_ZERO;
    status[dcw3_pkg::ST_LOADED] = loaded;
    status[dcw3_pkg::ST_RSVD_OK] = rsvd_ok;
    status[dcw3_pkg::ST_REMAP_USED] = remap_used_q;
    status[dcw3_pkg::ST_MDIS_USED] = mdis_used_q;
    status[dcw3_pkg::ST_REMAP_LOCK] = remap_lock;
    status[dcw3_pkg::ST_MDIS_LOCK] = mdis_lock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  // read data mux of registered state, zero when unmapped
  wire logic [31:0] rd_mux =
    sel_cfg ? cfg_q :
    sel_stat ? status :
    sel_remap ? remap_q :
    sel_mdis ? mdis_q :
    dcw3_pkg::RDATA_ZERO;

  // setup phase of a read, address already valid
  wire logic apb_rd_setup = PSEL & ~PENABLE & ~PWRITE;

  // read data taken at the setup edge, zero otherwise
  logic [31:0] prdata_q; // read data shown in the access phase
  logic [31:0] prdata_d; // its next value
  assign prdata_d = apb_rd_setup ? rd_mux : dcw3_pkg::RDATA_ZERO;

  // read data register, stands only during the access phase that follows
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_q <= dcw3_pkg::RDATA_ZERO;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // zero wait states, the read word is ready when the access phase starts
  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;
  assign PSLVERR = apb_acc & err_any;

  ////////////////////////////////////////////////////////////////////////////
  // settings toward the device

  assign PIN_REMAP = remap_q;
  assign MODULE_DISABLE = mdis_q;

  // user id from the loaded word, shared by both debug paths
  assign PROG_USER_ID = cfg_q[dcw3_pkg::UID_MSB:dcw3_pkg::UID_LSB];
  assign JTAG_USER_ID = cfg_q[dcw3_pkg::UID_MSB:dcw3_pkg::UID_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership

  // both muxes follow the loaded word, so ownership moves only at load
  // vbus_on_pin: usb drives it when the owner bit is one
  dcw3_pin_owner u_vbus_on (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .usb_owns(vbus_usb_owns),
    .usb_out(USB_VBUS_ON_O),
    .usb_oe(USB_VBUS_ON_OE),
    .usb_in(USB_VBUS_ON_I),
    .port_out(PORT_VBUS_ON_O),
    .port_oe(PORT_VBUS_ON_OE),
    .port_in(PORT_VBUS_ON_I),
    .pad_in(VBUS_ON_PIN_I),
    .pad_out(VBUS_ON_PIN_O),
    .pad_oe(VBUS_ON_PIN_OE)
  );

  // usb_id_pin: usb owns it when the owner bit is one
  dcw3_pin_owner u_usb_id (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .usb_owns(id_usb_owns),
    .usb_out(USB_ID_O),
    .usb_oe(USB_ID_OE),
    .usb_in(USB_ID_I),
    .port_out(PORT_USB_ID_O),
    .port_oe(PORT_USB_ID_OE),
    .port_in(PORT_USB_ID_I),
    .pad_in(USB_ID_PIN_I),
    .pad_out(USB_ID_PIN_O),
    .pad_oe(USB_ID_PIN_OE)
  );

endmodule

// ---- hw/dcw3_pkg.sv ----
// constants and types shared by the configuration word three block
package dcw3_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the apb bus
  localparam logic [11:0] OFS_CFG_WORD = 12'h000; // loaded configuration word
  localparam logic [11:0] OFS_STATUS = 12'h004; // load and lock state
  localparam logic [11:0] OFS_PIN_REMAP = 12'h008; // peripheral pin mapping
  localparam logic [11:0] OFS_MOD_DISABLE = 12'h00C; // peripheral module disable

  ////////////////////////////////////////////////////////////////////////////
  // configuration word field positions
  localparam int unsigned BIT_VBUS_ON_OWNER = 31; // vbus_on_pin_owner_sel
  localparam int unsigned BIT_USB_ID_OWNER = 30; // usb_id_pin_owner_sel
  localparam int unsigned BIT_REMAP_SINGLE = 29; // pin_remap_single_reconfig
  localparam int unsigned BIT_MDIS_SINGLE = 28; // module_disable_single_reconfig
  localparam int unsigned RSVD_MSB = 27; // reserved field top
  localparam int unsigned RSVD_LSB = 16; // reserved field bottom
  localparam int unsigned UID_MSB = 15; // user_identifier top
  localparam int unsigned UID_LSB = 0; // user_identifier bottom

  ////////////////////////////////////////////////////////////////////////////
  // status register field positions
  localparam int unsigned ST_LOADED = 0; // word has been loaded
  localparam int unsigned ST_RSVD_OK = 1; // reserved bits read as all ones
  localparam int unsigned ST_REMAP_USED = 2; // pin mapping written once
  localparam int unsigned ST_MDIS_USED = 3; // module disable written once
  localparam int unsigned ST_REMAP_LOCK = 4; // pin mapping now refuses writes
  localparam int unsigned ST_MDIS_LOCK = 5; // module disable now refuses writes

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  // word before load: port owns both pins, multiple reconfigs, id zero
  localparam logic [31:0] CFG_RESET = 32'h0FFF_0000;
  localparam logic [11:0] RSVD_ALL_ONES = 12'hFFF; // expected reserved value
  localparam logic [31:0] PIN_REMAP_RESET = 32'h0000_0000; // mapping at reset
  localparam logic [31:0] MOD_DISABLE_RESET = 32'h0000_0000; // disables at reset
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000; // unmapped read value

  ////////////////////////////////////////////////////////////////////////////
  // load sequencer states
  typedef enum logic [1:0] {
    LD_START,
    LD_REQ,
    LD_DONE
  } dcw3_load_t;

endpackage

// ---- hw/dcw3_pin_owner.sv ----
// ownership mux of one shared pin between the usb module and port logic
`timescale 1ns/1ps
module dcw3_pin_owner (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ownership select, high gives the pin to usb
  input wire logic usb_owns,
  // usb module side
  input wire logic usb_out,
  input wire logic usb_oe,
  output logic usb_in,
  // general port side
  input wire logic port_out,
  input wire logic port_oe,
  output logic port_in,
  // pad side
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // selected drive values
  wire logic out_d = usb_owns ? usb_out : port_out; // chosen level
  wire logic oe_d = usb_owns ? usb_oe : port_oe; // chosen enable

  // pad drive registered so the pin never glitches on the mux
  logic pad_out_q;
  logic pad_oe_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= 1'b0;
      pad_oe_q <= 1'b0;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
    end
  end

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // input routed only to the owner, the other side sees zero
  assign usb_in = usb_owns & pad_in;
  assign port_in = ~usb_owns & pad_in;

endmodule

// ---- bench/dcw3_properties.sv ----
// assertion checker for the configuration word three top ports
`timescale 1ns/1ps
module dcw3_properties (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // storage load
  input wire logic NV_RD_REQ,
  input wire logic NV_RD_VALID,
  input wire logic [31:0] NV_RD_DATA,
  // vbus pin
  input wire logic VBUS_ON_PIN_I,
  input wire logic VBUS_ON_PIN_O,
  input wire logic VBUS_ON_PIN_OE,
  input wire logic USB_VBUS_ON_O,
  input wire logic USB_VBUS_ON_OE,
  input wire logic USB_VBUS_ON_I,
  input wire logic PORT_VBUS_ON_O,
  input wire logic PORT_VBUS_ON_OE,
  input wire logic PORT_VBUS_ON_I,
  // settings and id
  input wire logic [31:0] PIN_REMAP,
  input wire logic [15:0] PROG_USER_ID,
  input wire logic [15:0] JTAG_USER_ID
);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the loaded word and of accepted writes
  logic [31:0] word_q; // expected loaded word
  logic ld_q; // word taken
  logic rused_q; // mapping written once
  logic mused_q; // disables written once
  wire take = NV_RD_REQ && NV_RD_VALID;
  wire acc = PSEL && PENABLE;
  wire wr_r = acc && PWRITE && PADDR == dcw3_pkg::OFS_PIN_REMAP;
  wire wr_m = acc && PWRITE && PADDR == dcw3_pkg::OFS_MOD_DISABLE;
  wire [1:0] vb_sel = word_q[31] ? {USB_VBUS_ON_O, USB_VBUS_ON_OE} :
    {PORT_VBUS_ON_O, PORT_VBUS_ON_OE};
  // shadow update, word taken once per reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      word_q <= dcw3_pkg::CFG_RESET;
      ld_q <= 1'h0;
      rused_q <= 1'h0;
      mused_q <= 1'h0;
    end else begin
      if (take) word_q <= NV_RD_DATA;
      if (take) ld_q <= 1'h1;
      if (wr_r && !PSLVERR) rused_q <= 1'h1;
      if (wr_m && !PSLVERR) mused_q <= 1'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  vbus_drive_a: assert property ($past(RESETN) |->
    {VBUS_ON_PIN_O, VBUS_ON_PIN_OE} == $past(vb_sel)) else $error("vbus pad wrong owner");
  vbus_route_a: assert property (USB_VBUS_ON_I == (word_q[31] & VBUS_ON_PIN_I) &&
    PORT_VBUS_ON_I == (!word_q[31] & VBUS_ON_PIN_I)) else $error("vbus input misrouted");
  uid_out_a: assert property (PROG_USER_ID == word_q[15:0] &&
    JTAG_USER_ID == word_q[15:0]) else $error("user id outputs wrong");
  remap_lock_a: assert property (wr_r |->
    PSLVERR == (!ld_q || (word_q[29] && rused_q))) else $error("remap lock wrong");
  mdis_lock_a: assert property (wr_m |->
    PSLVERR == (!ld_q || (word_q[28] && mused_q))) else $error("disable lock wrong");
  remap_hold_a: assert property (wr_r |=> PIN_REMAP ==
    ($past(PSLVERR) ? $past(PIN_REMAP) : $past(PWDATA))) else $error("remap value wrong");
  load_once_a: assert property ($past(RESETN) |-> NV_RD_REQ == !ld_q)
    else $error("load request wrong");
  word_read_a: assert property (acc && !PWRITE && PADDR == dcw3_pkg::OFS_CFG_WORD
    |-> PRDATA == $past(word_q) && !PSLVERR) else $error("word readback wrong");
  // main scenarios
  cover property (take);
  cover property (wr_r && PSLVERR && ld_q);
  cover property (word_q[31] && VBUS_ON_PIN_OE);
endmodule

bind dcw3_top dcw3_properties u_chk (.REF_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PSLVERR, .NV_RD_REQ, .NV_RD_VALID, .NV_RD_DATA, .VBUS_ON_PIN_I,
  .VBUS_ON_PIN_O, .VBUS_ON_PIN_OE, .USB_VBUS_ON_O, .USB_VBUS_ON_OE, .USB_VBUS_ON_I,
  .PORT_VBUS_ON_O, .PORT_VBUS_ON_OE, .PORT_VBUS_ON_I, .PIN_REMAP, .PROG_USER_ID,
  .JTAG_USER_ID);

// ---- bench/dcw3_nv_model.sv ----
// nonvolatile storage model answering the word load request
`timescale 1ns/1ps
module dcw3_nv_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // load handshake
  input wire logic req,
  output logic valid,
  output logic [31:0] data,
  // stored word and answer delay in cycles
  input wire logic [31:0] word,
  input wire logic [3:0] lat
);
  logic [3:0] cnt_q; // cycles spent waiting
  // count while asked, so replies can be prompt or slow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else if (!req) cnt_q <= 4'h0;
    else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
  end
  // word shown only with valid, inverted otherwise so stale data never matches
  assign valid = req && cnt_q == lat;
  assign data = valid ? word : ~word;
endmodule

// ---- bench/dcw3_top_tb.sv ----
// self-checking bench for the configuration word three block
`timescale 1ns/1ps
module dcw3_top_tb;
  // clock, reset and apb drive
  logic REF_CLK = 1'h0;
  logic RESETN = 1'h0;
  logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, NV_RD_REQ, NV_RD_VALID;
  logic [31:0] NV_RD_DATA;
  logic [31:0] nv_word = 32'h0000_0000;
  logic [3:0] nv_lat = 4'h0;
  // pin drive requests and outside pad level
  logic USB_VBUS_ON_O = 1'h0, USB_VBUS_ON_OE = 1'h0, USB_ID_O = 1'h0, USB_ID_OE = 1'h0;
  logic PORT_VBUS_ON_O = 1'h0, PORT_VBUS_ON_OE = 1'h0;
  logic PORT_USB_ID_O = 1'h0, PORT_USB_ID_OE = 1'h0;
  logic pad_ext = 1'h1;
  logic VBUS_ON_PIN_O, VBUS_ON_PIN_OE, USB_ID_PIN_O, USB_ID_PIN_OE;
  logic USB_VBUS_ON_I, USB_ID_I, PORT_VBUS_ON_I, PORT_USB_ID_I;
  logic [31:0] PIN_REMAP, MODULE_DISABLE;
  logic [15:0] PROG_USER_ID, JTAG_USER_ID;
  // wire level: own drive wins, else outside level
  wire VBUS_ON_PIN_I = VBUS_ON_PIN_OE ? VBUS_ON_PIN_O : pad_ext;
  wire USB_ID_PIN_I = USB_ID_PIN_OE ? USB_ID_PIN_O : pad_ext;
  int failures = 0;
  int checks = 0;
  logic [31:0] r, w;
  logic e;
  logic [11:0] a;
  logic [31:0] words [2] = '{32'hAFFF_1234, 32'h50F0_ABCD};
  logic [3:0] lats [2] = '{4'h9, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  dcw3_top dut (.REF_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .NV_RD_REQ, .NV_RD_VALID, .NV_RD_DATA, .VBUS_ON_PIN_I,
    .VBUS_ON_PIN_O, .VBUS_ON_PIN_OE, .USB_ID_PIN_I, .USB_ID_PIN_O, .USB_ID_PIN_OE,
    .USB_VBUS_ON_O, .USB_VBUS_ON_OE, .USB_VBUS_ON_I, .USB_ID_O, .USB_ID_OE, .USB_ID_I,
    .PORT_VBUS_ON_O, .PORT_VBUS_ON_OE, .PORT_VBUS_ON_I, .PORT_USB_ID_O, .PORT_USB_ID_OE,
    .PORT_USB_ID_I, .PIN_REMAP, .MODULE_DISABLE, .PROG_USER_ID, .JTAG_USER_ID);
  dcw3_nv_model u_nv (.clk(REF_CLK), .rst_n(RESETN), .req(NV_RD_REQ), .valid(NV_RD_VALID),
    .data(NV_RD_DATA), .word(nv_word), .lat(nv_lat));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    forever #10 REF_CLK = ~REF_CLK;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
      output logic [31:0] rd, output logic er);
    @(posedge REF_CLK);
    PSEL <= 1'h1;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  // verdict
  task automatic test_done;
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (3000) @(posedge REF_CLK);
    failures++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // slow load with full reserved field, then prompt load with broken field
  initial begin
    for (int k = 0; k < 2; k++) begin
      w = words[k];
      nv_word <= w;
      nv_lat <= lats[k];
      RESETN <= 1'h0;
      repeat (12) @(posedge REF_CLK);
      RESETN <= 1'h1;
      if (k == 0) begin
        apb(1'h1, dcw3_pkg::OFS_PIN_REMAP, 32'h0000_0001, r, e);
        chk(32'(e), 32'h0000_0001);
      end
      repeat (2) @(posedge REF_CLK);
      for (int n = 0; n < 40 && NV_RD_REQ !== 1'h0; n++) @(posedge REF_CLK);
      chk(32'(NV_RD_REQ), 32'h0000_0000);
      apb(1'h0, dcw3_pkg::OFS_CFG_WORD, 32'h0000_0000, r, e);
      chk(r, w);
      chk(32'({PROG_USER_ID, JTAG_USER_ID}), {w[15:0], w[15:0]});
      apb(1'h0, dcw3_pkg::OFS_STATUS, 32'h0000_0000, r, e);
      chk(r, {30'h0, w[27:16] == 12'hFFF, 1'h1});
      // usb and port ask for opposite levels
      USB_VBUS_ON_O <= 1'h1;
      PORT_VBUS_ON_OE <= 1'h1;
      USB_ID_O <= 1'h1;
      PORT_USB_ID_OE <= 1'h1;
      repeat (2) @(posedge REF_CLK);
      chk(32'({VBUS_ON_PIN_O, VBUS_ON_PIN_OE}), 32'({w[31], !w[31]}));
      chk(32'({USB_ID_PIN_O, USB_ID_PIN_OE}), 32'({w[30], !w[30]}));
      PORT_VBUS_ON_OE <= 1'h0;
      PORT_USB_ID_OE <= 1'h0;
      repeat (2) @(posedge REF_CLK);
      chk(32'({USB_VBUS_ON_I, PORT_VBUS_ON_I}), 32'({w[31], !w[31]}));
      chk(32'({USB_ID_I, PORT_USB_ID_I}), 32'({w[30], !w[30]}));
      // two writes each to mapping and disables
      for (int j = 0; j < 2; j++) begin
        a = (j == 0) ? dcw3_pkg::OFS_PIN_REMAP : dcw3_pkg::OFS_MOD_DISABLE;
        apb(1'h1, a, 32'h0000_00A5, r, e);
        chk(32'(e), 32'h0000_0000);
        apb(1'h1, a, 32'h0000_005A, r, e);
        chk(32'(e), 32'(w[29-j]));
        apb(1'h0, a, 32'h0000_0000, r, e);
        chk(r, w[29-j] ? 32'h0000_00A5 : 32'h0000_005A);
      end
      chk(MODULE_DISABLE, w[28] ? 32'h0000_00A5 : 32'h0000_005A);
      chk(PIN_REMAP, w[29] ? 32'h0000_00A5 : 32'h0000_005A);
      apb(1'h0, dcw3_pkg::OFS_STATUS, 32'h0000_0000, r, e);
      chk(r, {26'h0, w[28], w[29], 2'h3, w[27:16] == 12'hFFF, 1'h1});
      // unmapped read, then a write to the loaded word
      apb(1'h0, 12'h010, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      apb(1'h1, dcw3_pkg::OFS_CFG_WORD, ~w, r, e);
      chk(32'(e), 32'h0000_0001);
      apb(1'h0, dcw3_pkg::OFS_CFG_WORD, 32'h0000_0000, r, e);
      chk(r, w);
    end
    test_done;
  end
endmodule
